// >>> core/srs_cal_if.sv
// Carrier between the core and its calendar counter.
// Assumes both ends run on sys_clk.
interface srs_cal_if;
  import srs_pkg::*;

  logic           tick;
  srs_clk_bytes_t now;
  srs_clk_bytes_t nxt;
  logic           upd;

  modport core (output tick, output now, input nxt, input upd);
  modport cal  (input tick, input now, output nxt, output upd);
endinterface

// >>> core/srs_calendar.sv
// BCD clock/calendar stepper driven from crystal ticks.
// Assumes tick is one sys_clk pulse per crystal rising edge.
module srs_calendar
  import srs_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Calendar link to the core
  srs_cal_if.cal    cal
);
  import srs_pkg::*;

  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] acc_sum;
  logic             hund_due;

  // Fractional divide: 100 steps per 32768 ticks, exact on average
  assign acc_sum  = acc + ACC_W'(HUND_HZ);
  assign hund_due = cal.tick && (acc_sum >= ACC_W'(OSC_HZ));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc     <= '0;
      cal.upd <= 1'b0;
    end else begin
      cal.upd <= hund_due;
      if (hund_due) begin
        acc <= acc_sum - ACC_W'(OSC_HZ);
      end else if (cal.tick) begin
        acc <= acc_sum;
      end
    end
  end

  // Returns {carry, next}; wraps to lo after hi
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo,
                                         input logic       en);
    if (!en) begin
      return {1'b0, v};
    end else if (v >= hi) begin
      return {1'b1, lo};
    end else if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v + 8'h01};
  endfunction

  logic [7:0] yr;
  logic [7:0] mon;
  logic       leap;
  logic [7:0] mdays;
  logic [8:0] s_hund;
  logic [8:0] s_sec;
  logic [8:0] s_min;
  logic [8:0] s_hour;
  logic [8:0] s_day;
  logic [8:0] s_date;
  logic [8:0] s_mon;
  logic [8:0] s_year;
  logic [CENT_W-1:0] cent;

  assign yr   = cal.now[OFS_YEAR];
  assign mon  = cal.now[OFS_MONTH];
  assign cent = cal.now[OFS_HOUR][CENT_LSB +: CENT_W];

  // Every fourth year leaps; correct through 2099
  assign leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                      : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                         yr[3:0] == 4'h8);

  assign mdays = (mon == MON_FEB) ? (leap ? DAYS_29 : DAYS_28) :
                 (mon == MON_APR || mon == MON_JUN || mon == MON_SEP ||
                  mon == MON_NOV) ? DAYS_30 : DAYS_31;

  // Ripple carry through the BCD fields
  assign s_hund = bcd_step(cal.now[OFS_HUND], MAX_HUND, MIN_ZERO, 1'b1);
  assign s_sec  = bcd_step(cal.now[OFS_SEC], MAX_SEC, MIN_ZERO,
                           s_hund[8]);
  assign s_min  = bcd_step(cal.now[OFS_MIN], MAX_SEC, MIN_ZERO, s_sec[8]);
  assign s_hour = bcd_step({2'b00, cal.now[OFS_HOUR][HOUR_W-1:0]},
                           MAX_HOUR, MIN_ZERO, s_min[8]);
  assign s_day  = bcd_step(cal.now[OFS_DAY], MAX_DAY, MIN_ONE, s_hour[8]);
  assign s_date = bcd_step(cal.now[OFS_DATE], mdays, MIN_ONE, s_hour[8]);
  assign s_mon  = bcd_step(mon, MAX_MONTH, MIN_ONE, s_date[8]);
  assign s_year = bcd_step(yr, MAX_YEAR, MIN_ZERO, s_mon[8]);

  assign cal.nxt[OFS_HUND]  = s_hund[7:0];
  assign cal.nxt[OFS_SEC]   = s_sec[7:0];
  assign cal.nxt[OFS_MIN]   = s_min[7:0];
  assign cal.nxt[OFS_HOUR]  = {cent + CENT_W'(s_year[8]),
                               s_hour[HOUR_W-1:0]};
  assign cal.nxt[OFS_DAY]   = s_day[7:0];
  assign cal.nxt[OFS_DATE]  = s_date[7:0];
  assign cal.nxt[OFS_MONTH] = s_mon[7:0];
  assign cal.nxt[OFS_YEAR]  = s_year[7:0];

endmodule

// >>> core/srs_core.sv
// Serial clock/calendar storage core: two-wire target, 64-byte array,
// supply change-over and reset output.
// Assumes open-drain pads outside; all pins are asynchronous to sys_clk.
//
// Functional notes
// - Sixty-four bytes of storage, host addressable
// - Eight clock bytes held in BCD
// - Twelve control bytes held as plain storage; no alarm, watchdog or square-wave logic
// - Address pointer advances after every data byte
// - Two-wire bus, host master, core is target
// - Crystal 32.768 kHz ticks drive all calendar counting
// - Century to hundredths fields, 24-hour hours
// - Month lengths and leap years through 2099
// - Supply loss switches to battery, keeps state
// - External reset request drives reset output
module srs_core
  import srs_pkg::*;
#(
  parameter logic [6:0] I2C_ADDR   = srs_pkg::DEV_ADDR,
  parameter int         POR_CYCLES = srs_pkg::POR_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Two-wire serial bus
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  // Crystal time base
  input  wire logic osc_clk_in,
  // Supply monitor
  input  wire logic vcc_good,
  output logic      battery_select,
  // Reset request and open-drain reset output
  input  wire logic reset_request_input_n,
  output logic      rst_out,
  output logic      rst_oe_n
);
  import srs_pkg::*;

  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_OSC = 2;
  localparam int PIN_VCC = 3;
  localparam int PIN_RRQ = 4;
  localparam int NPINS   = 5;

  // Pin synchronisers
  logic [NPINS-1:0] pins;
  logic [NPINS-1:0] pin_meta;
  logic [NPINS-1:0] pin_sync;
  logic [2:0]       pin_last;

  assign pins = {reset_request_input_n, vcc_good, osc_clk_in, sda_in,
                 scl_in};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_meta <= 5'h1b;
      pin_sync <= 5'h1b;
      pin_last <= 3'h3;
    end else begin
      pin_meta <= pins;
      pin_sync <= pin_meta;
      pin_last <= pin_sync[2:0];
    end
  end

  // Edge decode on the second stage and its delayed copy
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic osc_rise;
  logic on_battery;
  logic rst_req;

  assign scl_s      = pin_sync[PIN_SCL];
  assign sda_s      = pin_sync[PIN_SDA];
  assign scl_rise   = scl_s && !pin_last[PIN_SCL];
  assign scl_fall   = !scl_s && pin_last[PIN_SCL];
  assign bus_start  = scl_s && pin_last[PIN_SCL] && !sda_s &&
                      pin_last[PIN_SDA];
  assign bus_stop   = scl_s && pin_last[PIN_SCL] && sda_s &&
                      !pin_last[PIN_SDA];
  assign osc_rise   = pin_sync[PIN_OSC] && !pin_last[PIN_OSC];
  assign on_battery = !pin_sync[PIN_VCC];
  assign rst_req    = !pin_sync[PIN_RRQ];

  // Storage array: clock bytes, control bytes, then general bytes
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  srs_cal_if cal_link ();

  srs_calendar u_calendar (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cal     (cal_link.cal)
  );

  assign cal_link.tick = osc_rise;

  // Serial target state
  srs_state_t        state;
  srs_state_t        next_state;
  logic [3:0]        bit_cnt;
  logic [3:0]        next_bit_cnt;
  logic [7:0]        shreg;
  logic [7:0]        next_shreg;
  logic [ADDR_W-1:0] ptr;
  logic [ADDR_W-1:0] next_ptr;
  logic              rd_mode;
  logic              next_rd_mode;
  logic              host_nack;
  logic              next_host_nack;
  logic              next_sda_oe_n;

  logic [7:0]        rd_byte;
  logic              byte_done;
  logic              addr_hit;
  logic              host_we;

  assign rd_byte   = mem[ptr];
  assign byte_done = (bit_cnt == 4'h8);
  assign addr_hit  = (shreg[7:1] == I2C_ADDR);
  assign host_we   = scl_fall && (state == ST_WDATA) && byte_done &&
                     !bus_start && !bus_stop && !on_battery;

  // Array write ports: host write wins over a calendar step
  for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_mem
    if (i < CLK_BYTES) begin : g_clk
      logic [7:0] rst_val;
      assign rst_val = (i == int'(OFS_DAY) || i == int'(OFS_DATE) ||
                        i == int'(OFS_MONTH)) ? RST_ONE : RST_ZERO;
      assign cal_link.now[i] = mem[i];
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          mem[i] <= rst_val;
        end else if (host_we && ptr == ADDR_W'(i)) begin
          mem[i] <= shreg;
        end else if (cal_link.upd) begin
          mem[i] <= cal_link.nxt[i];
        end
      end
    end else begin : g_ram
      // Control bytes sit at CTRL_FIRST onward
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          mem[i] <= RST_ZERO;
        end else if (host_we && ptr == ADDR_W'(i)) begin
          mem[i] <= shreg;
        end
      end
    end
  end

  // Target sequencing; decisions are taken on falling SCL so that
  // the driven bit is stable before the host's next rising edge
  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_ptr       = ptr;
    next_rd_mode   = rd_mode;
    next_host_nack = host_nack;
    next_sda_oe_n  = sda_oe_n;
    if (bus_start && !on_battery) begin
      next_state    = ST_ADDR;
      next_bit_cnt  = 4'h0;
      next_sda_oe_n = 1'b1;
    end else if (bus_stop || on_battery) begin
      // Bus is deselected while running from the battery
      next_state    = ST_IDLE;
      next_sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      case (state)
        ST_ADDR, ST_WORD, ST_WDATA: begin
          next_shreg   = {shreg[6:0], sda_s};
          next_bit_cnt = bit_cnt + 4'h1;
        end
        ST_RDATA: begin
          next_bit_cnt = bit_cnt + 4'h1;
        end
        ST_RACK: begin
          next_host_nack = sda_s;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (byte_done) begin
            if (addr_hit) begin
              next_sda_oe_n = 1'b0;
              next_rd_mode  = shreg[0];
              next_state    = ST_ADDR_ACK;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_RACK: begin
          if (state == ST_RACK && host_nack) begin
            next_sda_oe_n = 1'b1;
            next_state    = ST_IDLE;
          end else if (rd_mode) begin
            next_shreg    = rd_byte;
            next_sda_oe_n = rd_byte[7];
            next_ptr      = ptr + 6'h01;
            next_bit_cnt  = 4'h0;
            next_state    = ST_RDATA;
          end else begin
            next_sda_oe_n = 1'b1;
            next_bit_cnt  = 4'h0;
            next_state    = ST_WORD;
          end
        end
        ST_WORD: begin
          if (byte_done) begin
            next_ptr      = shreg[ADDR_W-1:0];
            next_sda_oe_n = 1'b0;
            next_state    = ST_WORD_ACK;
          end
        end
        ST_WORD_ACK, ST_WDATA_ACK: begin
          next_sda_oe_n = 1'b1;
          next_bit_cnt  = 4'h0;
          next_state    = ST_WDATA;
        end
        ST_WDATA: begin
          if (byte_done) begin
            next_ptr      = ptr + 6'h01;
            next_sda_oe_n = 1'b0;
            next_state    = ST_WDATA_ACK;
          end
        end
        ST_RDATA: begin
          if (byte_done) begin
            next_sda_oe_n  = 1'b1;
            next_host_nack = 1'b1;
            next_state     = ST_RACK;
          end else begin
            next_shreg    = {shreg[6:0], 1'b0};
            next_sda_oe_n = shreg[6];
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      ptr       <= '0;
      rd_mode   <= 1'b0;
      host_nack <= 1'b1;
      sda_oe_n  <= 1'b1;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shreg     <= next_shreg;
      ptr       <= next_ptr;
      rd_mode   <= next_rd_mode;
      host_nack <= next_host_nack;
      sda_oe_n  <= next_sda_oe_n;
    end
  end

  // Open-drain pads only ever pull low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      rst_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      rst_out <= 1'b0;
    end
  end

  // Supply change-over; the calendar keeps counting either way
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      battery_select <= 1'b0;
    end else begin
      battery_select <= on_battery;
    end
  end

  // Reset output: power-on hold, supply loss, or external request
  logic [31:0] por_cnt;
  logic        por_busy;
  logic        next_rst_oe_n;

  assign por_busy      = (por_cnt != 32'h0);
  assign next_rst_oe_n = !(por_busy || rst_req || on_battery);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      por_cnt  <= 32'(POR_CYCLES);
      rst_oe_n <= 1'b0;
    end else begin
      por_cnt  <= por_busy ? por_cnt - 32'h1 : por_cnt;
      rst_oe_n <= next_rst_oe_n;
    end
  end

endmodule

// >>> core/srs_pkg.sv
// Shared constants of the serial clock/calendar storage core.
// Assumes a 10 MHz system clock and a 32.768 kHz crystal time base pin.
package srs_pkg;

  // Storage array
  localparam int         MEM_DEPTH  = 64;
  localparam int         ADDR_W     = 6;
  localparam int         DATA_W     = 8;
  localparam int         CLK_BYTES  = 8;
  localparam int         CTRL_BYTES = 12;
  localparam int         CTRL_FIRST = CLK_BYTES;

  // Clock byte offsets
  localparam logic [5:0] OFS_HUND   = 6'h00;
  localparam logic [5:0] OFS_SEC    = 6'h01;
  localparam logic [5:0] OFS_MIN    = 6'h02;
  localparam logic [5:0] OFS_HOUR   = 6'h03;
  localparam logic [5:0] OFS_DAY    = 6'h04;
  localparam logic [5:0] OFS_DATE   = 6'h05;
  localparam logic [5:0] OFS_MONTH  = 6'h06;
  localparam logic [5:0] OFS_YEAR   = 6'h07;

  // Field positions inside the hour byte
  localparam int         CENT_LSB   = 6;
  localparam int         CENT_W     = 2;
  localparam int         HOUR_W     = 6;

  // BCD limits
  localparam logic [7:0] MAX_HUND   = 8'h99;
  localparam logic [7:0] MAX_SEC    = 8'h59;
  localparam logic [7:0] MAX_HOUR   = 8'h23;
  localparam logic [7:0] MAX_DAY    = 8'h07;
  localparam logic [7:0] MAX_MONTH  = 8'h12;
  localparam logic [7:0] MAX_YEAR   = 8'h99;
  localparam logic [7:0] MIN_ZERO   = 8'h00;
  localparam logic [7:0] MIN_ONE    = 8'h01;
  localparam logic [7:0] DAYS_28    = 8'h28;
  localparam logic [7:0] DAYS_29    = 8'h29;
  localparam logic [7:0] DAYS_30    = 8'h30;
  localparam logic [7:0] DAYS_31    = 8'h31;
  localparam logic [7:0] MON_FEB    = 8'h02;
  localparam logic [7:0] MON_APR    = 8'h04;
  localparam logic [7:0] MON_JUN    = 8'h06;
  localparam logic [7:0] MON_SEP    = 8'h09;
  localparam logic [7:0] MON_NOV    = 8'h11;

  // Reset values
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_ONE    = 8'h01;

  // Time base
  localparam int         SYS_CLK_HZ = 10_000_000;
  localparam int         OSC_HZ     = 32_768;
  localparam int         HUND_HZ    = 100;
  localparam int         ACC_W      = 17;

  // Power-on reset hold time in microseconds and its cycle count
  localparam int         POR_US     = 1000;
  localparam int         POR_CYC    = (SYS_CLK_HZ / 1_000_000) * POR_US;

  // Target address on the serial bus (arbitrary value)
  localparam logic [6:0] DEV_ADDR   = 7'h5a;

  // Serial target states
  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_WORD      = 9'h008,
    ST_WORD_ACK  = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RACK      = 9'h100
  } srs_state_t;

  typedef logic [CLK_BYTES-1:0][DATA_W-1:0] srs_clk_bytes_t;

endpackage

// >>> tb/srs_core_assertions.sv
// Pin-level checks of the serial clock/storage core.
// Assumes it is bound to srs_core and sees only its ports.
module srs_core_assertions #(
  parameter int POR_CYCLES = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Time base and supply
  input wire logic osc_clk_in,
  input wire logic vcc_good,
  input wire logic battery_select,
  // Reset pins
  input wire logic reset_request_input_n,
  input wire logic rst_out,
  input wire logic rst_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking

  rst_hold_a: assert property (
    !rst_n |=> !rst_oe_n && sda_oe_n && !battery_select)
    else $error("outputs not at reset values");
  req_reset_a: assert property (disable iff (!rst_n)
    !reset_request_input_n [*3] |=> !rst_oe_n)
    else $error("reset request did not assert reset output");
  por_hold_a: assert property (disable iff (!rst_n)
    $rose(rst_n) |-> !rst_oe_n [*8])
    else $error("reset output released too soon");
  rst_release_a: assert property (disable iff (!rst_n)
    $rose(rst_oe_n) |-> $past(reset_request_input_n, 3)
    && $past(vcc_good, 3))
    else $error("reset output released while a cause stood");
  supply_reset_a: assert property (disable iff (!rst_n)
    !vcc_good [*3] |=> !rst_oe_n)
    else $error("supply loss did not assert reset output");
  batt_on_a: assert property (disable iff (!rst_n)
    !vcc_good [*3] |=> battery_select)
    else $error("battery not selected on supply loss");
  batt_off_a: assert property (disable iff (!rst_n)
    vcc_good [*3] |=> !battery_select)
    else $error("battery selected with supply good");
  bus_quiet_a: assert property (disable iff (!rst_n)
    !vcc_good [*4] |=> sda_oe_n)
    else $error("data line driven during supply loss");
  pin_low_a: assert property (disable iff (!rst_n)
    (!sda_oe_n |-> !sda_out) and (!rst_oe_n |-> !rst_out))
    else $error("open-drain pin driven high");
  ack_edge_a: assert property (disable iff (!rst_n)
    $changed(sda_oe_n) && vcc_good |-> !scl_in)
    else $error("data line changed while bus clock high");

  // Cycles since reset release, saturating so it never wraps on long runs
  int rel_cnt;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rel_cnt <= 0;
    end else if (rel_cnt < POR_CYCLES) begin
      rel_cnt <= rel_cnt + 1;
    end
  end

  por_count_a: assert property (disable iff (!rst_n)
    rel_cnt < POR_CYCLES |-> !rst_oe_n)
    else $error("reset output released before hold time");
endmodule

// >>> tb/srs_core_tb.sv
// Self-checking bench of the serial clock/storage core.
// Assumes srs_i2c_host as bus master; crystal ticks sped up.
module srs_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         POR  = 20;
  localparam logic [6:0] ADDR = 7'h5a;

  logic       sys_clk    = 1'b0;
  logic       rst_n      = 1'b0;
  logic       osc_clk_in = 1'b0;
  logic       vcc_good   = 1'b1;
  logic       req_n      = 1'b1;
  logic       sda_out;
  logic       sda_oe_n;
  logic       battery_select;
  logic       rst_out;
  logic       rst_oe_n;
  logic       scl;
  logic       sda_low;
  logic       sda_wire;
  logic [7:0] rq[$];
  int         error_cnt    = 0;
  int         total_checks = 0;

  always #50 sys_clk = ~sys_clk;
  // Pull-up wins whenever nobody pulls low
  assign sda_wire = sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);

  srs_i2c_host host (
    .sys_clk (sys_clk),
    .sda_wire(sda_wire),
    .scl     (scl),
    .sda_low (sda_low)
  );

  srs_core #(
    .I2C_ADDR  (ADDR),
    .POR_CYCLES(POR)
  ) dut (
    .sys_clk              (sys_clk),
    .rst_n                (rst_n),
    .scl_in               (scl),
    .sda_in               (sda_wire),
    .sda_out              (sda_out),
    .sda_oe_n             (sda_oe_n),
    .osc_clk_in           (osc_clk_in),
    .vcc_good             (vcc_good),
    .battery_select       (battery_select),
    .reset_request_input_n(req_n),
    .rst_out              (rst_out),
    .rst_oe_n             (rst_oe_n)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] ptr, input logic [7:0] d[$]);
    logic ack;
    host.start();
    host.put_byte({ADDR, 1'b0}, ack);
    chk(ack, 1'b1);
    host.put_byte({2'b00, ptr}, ack);
    chk(ack, 1'b1);
    foreach (d[i]) begin
      host.put_byte(d[i], ack);
      chk(ack, 1'b1);
    end
    host.stop();
  endtask

  // Pointer write, repeated START, then a read burst into rq
  task automatic rd(input logic [5:0] ptr, input int n);
    logic       ack;
    logic [7:0] b;
    rq = {};
    host.start();
    host.put_byte({ADDR, 1'b0}, ack);
    host.put_byte({2'b00, ptr}, ack);
    host.start();
    host.put_byte({ADDR, 1'b1}, ack);
    chk(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      host.get_byte(i < n - 1, b);
      rq.push_back(b);
    end
    host.stop();
  endtask

  task automatic t_reset();
    int n;
    cyc(11);
    chk({sda_oe_n, rst_oe_n, battery_select}, 3'b100);
    cyc(1);
    rst_n <= 1'b1;
    n = 0;
    while (rst_oe_n !== 1'b1) begin
      cyc(1);
      n++;
      if (n > POR + 10) begin
        chk(1'b0, 1'b1);
        finish_test();
      end
    end
    chk(n >= POR, 1'b1);
  endtask

  // Burst across the top of the array wraps to byte zero
  task automatic t_wrap();
    wr(6'h3e, '{8'ha5, 8'h5a, 8'hc3});
    rd(6'h3e, 3);
    chk(rq[0], 8'ha5);
    chk(rq[1], 8'h5a);
    chk(rq[2], 8'hc3);
    wr(6'h13, '{8'h3c});
    rd(6'h13, 1);
    chk(rq[0], 8'h3c);
  endtask

  task automatic t_badaddr();
    logic ack;
    host.start();
    host.put_byte({ADDR ^ 7'h01, 1'b1}, ack);
    chk(ack, 1'b0);
    host.stop();
  endtask

  // 328 crystal rises give exactly one hundredths step
  task automatic t_cal();
    logic [63:0] set_v[4];
    logic [63:0] exp_v[4];
    logic [7:0]  q[$];
    set_v = '{64'h2402280723595999, 64'h2302280323595999,
              64'h9912310523595999, 64'h2404300223595999};
    exp_v = '{64'h2402290100000000, 64'h2303010400000000,
              64'h0001010640000000, 64'h2405010300000000};
    foreach (set_v[k]) begin
      q = {};
      for (int i = 0; i < 8; i++) q.push_back(set_v[k][8*i +: 8]);
      wr(6'h00, q);
      repeat (328) begin
        osc_clk_in <= 1'b1;
        cyc(4);
        osc_clk_in <= 1'b0;
        cyc(4);
      end
      cyc(4);
      rd(6'h00, 8);
      for (int i = 0; i < 8; i++) begin
        chk(rq[i], exp_v[k][8*i +: 8]);
      end
    end
  endtask

  task automatic t_supply();
    logic ack;
    vcc_good <= 1'b0;
    cyc(6);
    chk({battery_select, rst_oe_n}, 2'b10);
    host.start();
    host.put_byte({ADDR, 1'b0}, ack);
    chk(ack, 1'b0);
    host.stop();
    vcc_good <= 1'b1;
    cyc(6);
    chk({battery_select, rst_oe_n}, 2'b01);
    rd(6'h3e, 1);
    chk(rq[0], 8'ha5);
  endtask

  task automatic t_request();
    req_n <= 1'b0;
    cyc(5);
    chk(rst_oe_n, 1'b0);
    req_n <= 1'b1;
    cyc(5);
    chk(rst_oe_n, 1'b1);
  endtask

  initial begin
    t_reset();
    t_wrap();
    t_badaddr();
    t_cal();
    t_supply();
    t_request();
    finish_test();
  end
endmodule

bind srs_core srs_core_assertions #(
  .POR_CYCLES(POR_CYCLES)
) chk_i (
  .sys_clk              (sys_clk),
  .rst_n                (rst_n),
  .scl_in               (scl_in),
  .sda_in               (sda_in),
  .sda_out              (sda_out),
  .sda_oe_n             (sda_oe_n),
  .osc_clk_in           (osc_clk_in),
  .vcc_good             (vcc_good),
  .battery_select       (battery_select),
  .reset_request_input_n(reset_request_input_n),
  .rst_out              (rst_out),
  .rst_oe_n             (rst_oe_n)
);

// >>> tb/srs_i2c_host.sv
// Two-wire bus master model for the core's serial pins.
// Assumes the bench resolves the data wire with a pull-up.
module srs_i2c_host #(
  parameter int HALF = 10
) (
  // Clock
  input  wire logic sys_clk,
  // Bus wires
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Data only moves while the bus clock is low, except START and STOP
  task automatic start();
    cyc(2);
    sda_low <= 1'b0;
    cyc(HALF);
    scl <= 1'b1;
    cyc(HALF);
    sda_low <= 1'b1;
    cyc(HALF);
    scl <= 1'b0;
  endtask

  task automatic stop();
    cyc(2);
    sda_low <= 1'b1;
    cyc(HALF);
    scl <= 1'b1;
    cyc(HALF);
    sda_low <= 1'b0;
    cyc(HALF);
  endtask

  // MSB first, then the target's acknowledge slot
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      cyc(2);
      sda_low <= !b[i];
      cyc(HALF);
      scl <= 1'b1;
      cyc(HALF);
      scl <= 1'b0;
    end
    cyc(2);
    sda_low <= 1'b0;
    cyc(HALF);
    scl <= 1'b1;
    cyc(HALF / 2);
    @(negedge sys_clk);
    ack = !sda_wire;
    cyc(HALF / 2);
    scl <= 1'b0;
  endtask

  // Sampled mid-high, well after the target has set each bit
  task automatic get_byte(input logic more, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      cyc(HALF);
      scl <= 1'b1;
      cyc(HALF / 2);
      @(negedge sys_clk);
      b[i] = sda_wire;
      cyc(HALF / 2);
      scl <= 1'b0;
    end
    cyc(2);
    sda_low <= more;
    cyc(HALF);
    scl <= 1'b1;
    cyc(HALF);
    scl <= 1'b0;
    cyc(2);
    sda_low <= 1'b0;
  endtask
endmodule
